// ==== rtl/ccd_pkg.sv ====
package ccd_pkg;
  // ****************************************
  // Widths
  // ****************************************
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int PC_W = 13;
  localparam int LIT_W = 11;
  localparam int OPC_W = 14;
  localparam int WDT_W = 8;
  localparam int PRE_W = 8;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;

  // ****************************************
  // Opcode encodings (14-bit words and high-bit opcode fields)
  // ****************************************
  localparam logic [13:0] OPC_WATCHDOG_RESTART = 14'h0064;
  localparam logic [13:0] OPC_ZERO_ACC_MASK = 14'h3F80;
  localparam logic [13:0] OPC_ZERO_ACC = 14'h0100;
  localparam logic [5:0] OPC_ZERO_REG_HI = 6'h01;
  localparam logic [5:0] OPC_INVERT_HI = 6'h09;
  localparam logic [5:0] OPC_MINUS_ONE_HI = 6'h03;
  localparam logic [2:0] OPC_CALL_HI = 3'h4;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int DEST_BIT = 7;
  localparam int LATCH_HI_LSB = 3;
  localparam int LATCH_HI_MSB = 4;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] WDT_CLEAR = 8'h00;
  localparam logic [7:0] PRE_CLEAR = 8'h00;
  localparam logic [12:0] PC_RST = 13'h0000;

  typedef enum logic [1:0] {
    CCD_EXEC = 2'b00,
    CCD_CALL_FLUSH = 2'b01
  } ccd_state_t;
endpackage : ccd_pkg

// ==== rtl/ccd_stack.sv ====
`timescale 1ns/1ps
module ccd_stack #(
  parameter int DEPTH = ccd_pkg::STACK_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic push,
  input wire logic pop,
  input wire logic [ccd_pkg::PC_W-1:0] push_data,
  output logic [ccd_pkg::PC_W-1:0] stack_top_entry,
  output logic [ccd_pkg::SP_W-1:0] depth_ptr
);
  import ccd_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][PC_W-1:0] mem;
    logic [SP_W-1:0] sp;
  } ccd_stack_st_t;

  ccd_stack_st_t st;
  ccd_stack_st_t next_st;

  // ****************************************
  // Circular return stack; overflow wraps silently
  // ****************************************
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.sp] = push_data;
      next_st.sp = st.sp + 3'h1;
    end else if (pop) begin
      next_st.sp = st.sp - 3'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign stack_top_entry = st.mem[st.sp - 3'h1];
  assign depth_ptr = st.sp;
endmodule : ccd_stack

// ==== rtl/ccd_exec.sv ====
`timescale 1ns/1ps
// How it works
// - Watchdog restart clears watchdog counter
// - Watchdog restart also clears prescaler
// - Watchdog restart sets expiry and power-down flags
// - Call pushes program counter plus one
// - Call loads 11-bit literal into low bits
// - Call takes upper bits from latch high
// - Call takes two cycles, flags unchanged
// - Invert register, set null flag on zero result, pick destination
// - Zero register and set null flag
// - Decrement register, null flag, pick destination
// - Zero accumulator and set null flag
module ccd_exec (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [ccd_pkg::OPC_W-1:0] instr,
  input wire logic [ccd_pkg::DATA_W-1:0] file_rd_data,
  input wire logic [ccd_pkg::DATA_W-1:0] program_counter_latch_high,
  input wire logic watchdog_tick,
  input wire logic prescale_tick,
  output logic [ccd_pkg::ADDR_W-1:0] file_addr,
  output logic file_wr_en,
  output logic [ccd_pkg::DATA_W-1:0] file_wr_data,
  output logic [ccd_pkg::DATA_W-1:0] accumulator,
  output logic result_null_flag,
  output logic watchdog_expiry_flag,
  output logic power_down_flag,
  output logic [ccd_pkg::WDT_W-1:0] watchdog_counter,
  output logic [ccd_pkg::PRE_W-1:0] watchdog_prescaler,
  output logic [ccd_pkg::PC_W-1:0] program_counter,
  output logic [ccd_pkg::PC_W-1:0] stack_top_entry,
  output logic flush,
  output logic illegal_op
);
  import ccd_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    ccd_state_t state;
    logic [DATA_W-1:0] acc;
    logic znull;
    logic expiry;
    logic pdown;
    logic [WDT_W-1:0] wdt;
    logic [PRE_W-1:0] pre;
    logic [PC_W-1:0] pc;
    logic [ADDR_W-1:0] waddr;
    logic wen;
    logic [DATA_W-1:0] wdata;
    logic illegal;
  } ccd_exec_st_t;

  ccd_exec_st_t st;
  ccd_exec_st_t next_st;
  logic push;
  logic [PC_W-1:0] ret_addr;

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic match_hi6(input logic [OPC_W-1:0] op, input logic [5:0] hi);
    match_hi6 = (op[13:8] == hi);
  endfunction : match_hi6

  function automatic logic is_zero(input logic [DATA_W-1:0] v);
    is_zero = (v == 8'h00);
  endfunction : is_zero

  logic dec_wdt;
  logic dec_call;
  logic dec_inv;
  logic dec_zreg;
  logic dec_dec;
  logic dec_zacc;
  logic dest_reg;
  logic [DATA_W-1:0] alu;

  always_comb begin
    dec_wdt = (instr == OPC_WATCHDOG_RESTART);
    dec_call = (instr[13:11] == OPC_CALL_HI);
    dec_inv = match_hi6(instr, OPC_INVERT_HI);
    dec_zreg = match_hi6(instr, OPC_ZERO_REG_HI) && instr[DEST_BIT];
    dec_zacc = ((instr & OPC_ZERO_ACC_MASK) == OPC_ZERO_ACC);
    dec_dec = match_hi6(instr, OPC_MINUS_ONE_HI);
    dest_reg = instr[DEST_BIT];
    alu = dec_inv ? ~file_rd_data : file_rd_data - 8'h01;
  end

  // ****************************************
  // Execute
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.wen = 1'b0;
    next_st.illegal = 1'b0;
    push = 1'b0;
    ret_addr = st.pc + 13'h0001;
    // Time base keeps running unless a restart lands this cycle
    if (prescale_tick) begin
      next_st.pre = st.pre + 8'h01;
    end
    if (watchdog_tick) begin
      next_st.wdt = st.wdt + 8'h01;
    end
    case (st.state)
      CCD_CALL_FLUSH: begin
        // Second cycle of call: fetched word discarded, flags untouched
        next_st.state = CCD_EXEC;
      end
      default: begin
        if (instr_valid) begin
          next_st.pc = st.pc + 13'h0001;
          if (dec_wdt) begin
            next_st.wdt = WDT_CLEAR;
            next_st.pre = PRE_CLEAR;
            next_st.expiry = 1'b1;
            next_st.pdown = 1'b1;
          end else if (dec_call) begin
            push = 1'b1;
            next_st.pc = {program_counter_latch_high[LATCH_HI_MSB:LATCH_HI_LSB],
                          instr[LIT_W-1:0]};
            next_st.state = CCD_CALL_FLUSH;
          end else if (dec_inv || dec_dec) begin
            next_st.znull = is_zero(alu);
            if (dest_reg) begin
              next_st.wen = 1'b1;
              next_st.waddr = instr[ADDR_W-1:0];
              next_st.wdata = alu;
            end else begin
              next_st.acc = alu;
            end
          end else if (dec_zreg) begin
            next_st.wen = 1'b1;
            next_st.waddr = instr[ADDR_W-1:0];
            next_st.wdata = 8'h00;
            next_st.znull = 1'b1;
          end else if (dec_zacc) begin
            next_st.acc = ACC_RST;
            next_st.znull = 1'b1;
          end else begin
            // Other opcodes belong to the rest of the core
            next_st.illegal = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.expiry <= 1'b1;
      st.pdown <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  ccd_stack #(
    .DEPTH(STACK_DEPTH)
  ) u_stack (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .push(push),
    .pop(1'b0),
    .push_data(ret_addr),
    .stack_top_entry(stack_top_entry),
    .depth_ptr()
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign file_addr = instr[ADDR_W-1:0];
  assign file_wr_en = st.wen;
  assign file_wr_data = st.wdata;
  assign accumulator = st.acc;
  assign result_null_flag = st.znull;
  assign watchdog_expiry_flag = st.expiry;
  assign power_down_flag = st.pdown;
  assign watchdog_counter = st.wdt;
  assign watchdog_prescaler = st.pre;
  assign program_counter = st.pc;
  assign flush = (st.state == CCD_CALL_FLUSH);
  assign illegal_op = st.illegal;
endmodule : ccd_exec

// ==== tb/ccd_exec_sva.sv ====
`timescale 1ns/1ps
module ccd_exec_sva (
  input logic ref_clk,
  input logic rst_n,
  input logic instr_valid,
  input logic [13:0] instr,
  input logic [7:0] file_rd_data,
  input logic [7:0] program_counter_latch_high,
  input logic file_wr_en,
  input logic [7:0] file_wr_data,
  input logic [7:0] accumulator,
  input logic result_null_flag,
  input logic watchdog_expiry_flag,
  input logic power_down_flag,
  input logic [7:0] watchdog_counter,
  input logic [7:0] watchdog_prescaler,
  input logic [12:0] program_counter,
  input logic [12:0] stack_top_entry,
  input logic flush
);
  import ccd_pkg::*;
  // ****************************************
  // Decode of taken opcodes
  // ****************************************
  logic tk, rs, cl, iv, dc, zr, za;
  logic [10:0] lit;
  logic [1:0] lat;
  assign tk = instr_valid && !flush;
  assign rs = tk && instr == OPC_WATCHDOG_RESTART;
  assign cl = tk && instr[13:11] == OPC_CALL_HI;
  assign iv = tk && instr[13:8] == OPC_INVERT_HI;
  assign dc = tk && instr[13:8] == OPC_MINUS_ONE_HI;
  assign zr = tk && instr[13:7] == {OPC_ZERO_REG_HI, 1'b1};
  assign za = tk && (instr & OPC_ZERO_ACC_MASK) == OPC_ZERO_ACC;
  assign lit = instr[10:0];
  assign lat = program_counter_latch_high[4:3];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wdt_zero_a: assert property (rs |=> watchdog_counter == 8'h00)
    else $error("counter not cleared");
  pre_zero_a: assert property (rs |=> watchdog_prescaler == 8'h00)
    else $error("prescaler not cleared");
  wdt_flags_a: assert property (rs |=> watchdog_expiry_flag && power_down_flag)
    else $error("flags not set");
  call_push_a: assert property (cl |=> stack_top_entry == $past(program_counter) + 13'h1)
    else $error("bad return address");
  call_low_a: assert property (cl |=> program_counter[10:0] == $past(lit))
    else $error("bad target low bits");
  call_high_a: assert property (cl |=> program_counter[12:11] == $past(lat))
    else $error("bad target high bits");
  call_two_a: assert property (cl |=> flush && $stable(result_null_flag) ##1 !flush)
    else $error("call timing wrong");
  inv_file_a: assert property (iv && instr[7] |=> file_wr_en && file_wr_data == ~$past(file_rd_data))
    else $error("invert result wrong");
  zero_reg_a: assert property (zr |=> file_wr_en && file_wr_data == 8'h00 && result_null_flag)
    else $error("zero register wrong");
  dec_acc_a: assert property (dc && !instr[7] |=> accumulator == $past(file_rd_data) - 8'h01)
    else $error("decrement result wrong");
  zero_acc_a: assert property (za |=> accumulator == 8'h00 && result_null_flag)
    else $error("zero accumulator wrong");
  one_cycle_a: assert property (rs || iv || dc || zr || za |=> !flush)
    else $error("single op flushed");
endmodule : ccd_exec_sva
bind ccd_exec ccd_exec_sva ccd_exec_sva_inst (.*);

// ==== tb/ccd_exec_test.sv ====
`timescale 1ns/1ps
module ccd_exec_test;
  import ccd_pkg::*;
  // ****************************************
  // Stimulus and checks
  // ****************************************
  logic ref_clk = 1'b0, rst_n = 1'b0, instr_valid = 1'b0;
  logic watchdog_tick = 1'b0, prescale_tick = 1'b0;
  logic [13:0] instr = 14'h0000;
  logic [7:0] file_rd_data = 8'h00, program_counter_latch_high = 8'hF5;
  logic [7:0] file_wr_data, accumulator, watchdog_counter, watchdog_prescaler;
  logic [12:0] program_counter, stack_top_entry;
  logic file_wr_en, result_null_flag, watchdog_expiry_flag, power_down_flag, flush;
  logic illegal_op;
  int err_count = 0, compares = 0;
  always #10 ref_clk = ~ref_clk;
  ccd_exec ccd_exec_inst (.file_addr(), .*);
  task chk(input logic [12:0] got, input logic [12:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Hold keeps a zero-acc op up in the flush cycle, where it must be ignored
  task op(input logic [13:0] o, input logic [7:0] rd, input logic hold);
    @(posedge ref_clk);
    instr_valid <= 1'b1;
    instr <= o;
    file_rd_data <= rd;
    @(posedge ref_clk);
    instr_valid <= hold;
    instr <= OPC_ZERO_ACC;
    #1;
  endtask : op
  task stop_test;
    $display("Errors %0d in %0d compares", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  initial begin
    #100000;
    err_count++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    watchdog_tick <= 1'b1;
    prescale_tick <= 1'b1;
    repeat (3) @(posedge ref_clk);
    op(OPC_WATCHDOG_RESTART, 8'h00, 1'b0);
    chk(watchdog_counter, 8'h00);
    chk(watchdog_prescaler, 8'h00);
    chk({watchdog_expiry_flag, power_down_flag}, 2'b11);
    @(posedge ref_clk);
    watchdog_tick <= 1'b0;
    prescale_tick <= 1'b0;
    op(14'h0905, 8'h5A, 1'b0);
    chk({accumulator, result_null_flag}, 9'h14A);
    op(14'h017F, 8'h00, 1'b0);
    chk({accumulator, result_null_flag}, 9'h001);
    op(14'h0320, 8'h00, 1'b0);
    chk({accumulator, result_null_flag}, 9'h1FE);
    op(14'h03A0, 8'h01, 1'b0);
    chk({file_wr_en, file_wr_data, result_null_flag}, 10'h201);
    chk(accumulator, 8'hFF);
    op(14'h27FF, 8'h00, 1'b1);
    chk(stack_top_entry, 13'h0006);
    chk(program_counter, 13'h17FF);
    chk({flush, result_null_flag}, 2'b11);
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1;
    chk({flush, accumulator}, 9'h0FF);
    op(14'h09C0, 8'h0F, 1'b0);
    chk({file_wr_en, file_wr_data, result_null_flag}, 10'h3E0);
    op(14'h01FF, 8'h33, 1'b0);
    chk({file_wr_en, file_wr_data, result_null_flag, flush}, 11'h402);
    // Foreign opcode only raises the pulse; accumulator and null flag stay put
    op(14'h3000, 8'h00, 1'b0);
    chk({illegal_op, flush, accumulator, result_null_flag}, 11'h5FF);
    stop_test();
  end
endmodule : ccd_exec_test
